// ### core/ssa_pkg.sv
package ssa_pkg;

   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;

   // register byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam logic [3:0] ADDR_MASK = 4'h8;

   // control word bit positions
   localparam int BIT_EN    = 0;
   localparam int BIT_MST   = 1;
   localparam int BIT_MODE  = 2;
   localparam int BIT_STRS  = 4;
   localparam int BIT_ACK   = 5;
   localparam int BIT_START = 6;
   localparam int BIT_STOP  = 7;
   localparam int BIT_GCEN  = 8;
   localparam int BIT_STREN = 9;
   localparam int BIT_ABORT = 15;

   // status and mask bit positions
   localparam int EVT_STOP    = 0;
   localparam int EVT_TIMEOUT = 1;
   localparam int EVT_GCALL   = 2;
   localparam int EVT_ABORT   = 3;
   localparam int EVT_STRETCH = 4;
   localparam int EVT_W       = 5;

   localparam logic [EVT_W-1:0] STAT_RESET = 5'h00;
   localparam logic [EVT_W-1:0] MASK_RESET = 5'h00;

   // timing
   localparam int CLK_PERIOD_NS  = 100;
   localparam int STOP_PHASE_NS  = 5000;
   localparam int STOP_PHASE_CYC = (STOP_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ABORT_CYC      = 4;

   localparam logic [3:0] STRETCH_AT_8 = 4'h8;
   localparam logic [3:0] STRETCH_AT_9 = 4'h9;
   localparam logic [3:0] BITS_PER_ACK = 4'h9;
   localparam logic [7:0] GC_ADDR      = 8'h00;

   typedef enum logic [1:0] {
      SSA_STOP_IDLE  = 2'b00,
      SSA_STOP_LOW   = 2'b01,
      SSA_STOP_SCLHI = 2'b10,
      SSA_STOP_SDAHI = 2'b11
   } ssa_stop_t;
endpackage

// ### core/ssa_ctrl.sv
`timescale 1ns/1ps
module ssa_ctrl #(
   parameter int STOP_PHASE = ssa_pkg::STOP_PHASE_CYC,
   parameter int ABORT_LEN  = ssa_pkg::ABORT_CYC
) (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   // register port
   input  wire logic [ssa_pkg::ADDR_W-1:0]  addr,
   input  wire logic [ssa_pkg::DATA_W-1:0]  wdata,
   input  wire logic                        wr_en,
   input  wire logic                        rd_en,
   output logic      [ssa_pkg::DATA_W-1:0]  rdata,
   output logic                             irq,
   // rest of the unit
   input  wire logic                        start_done,
   input  wire logic                        addr_match_evt,
   input  wire logic                        arb_lost_evt,
   input  wire logic                        timeout_en,
   input  wire logic                        timeout_expired,
   output logic                             timeout_start,
   output logic                             controller_enable,
   output logic                             master_select,
   output logic                             transfer_mode,
   output logic                             start_request,
   output logic                             stretch_point_select,
   output logic                             ack_select,
   // bus pins, open drain
   input  wire logic                        scl_in,
   output logic                             scl_out,
   output logic                             scl_oe_n,
   input  wire logic                        sda_in,
   output logic                             sda_out,
   output logic                             sda_oe_n
);
   localparam int ABORT_BOUND = ABORT_LEN + 2;

   logic                        stop_request;
   logic                        general_call_accept;
   logic                        stretch_enable;
   logic                        controller_abort;
   logic [3:0]                  abort_cnt;
   logic                        abort_done;
   logic                        next_en;
   logic                        next_mst;
   logic                        wr_ctrl;
   logic                        set_stop;
   logic                        set_start;
   logic                        stop_done;
   logic                        timeout_hit;
   ssa_pkg::ssa_stop_t          stop_state;
   logic [7:0]                  phase_cnt;
   logic                        scl_m, scl_s, scl_q;
   logic                        sda_m, sda_s, sda_q;
   logic                        scl_rise, scl_fall, bus_start;
   logic [3:0]                  bit_cnt;
   logic [3:0]                  next_bit;
   logic                        first_byte;
   logic [7:0]                  shreg;
   logic                        gc_evt;
   logic                        gc_drive;
   logic                        hold;
   logic                        hold_set;
   logic [ssa_pkg::EVT_W-1:0]   status;
   logic [ssa_pkg::EVT_W-1:0]   mask;
   logic [ssa_pkg::EVT_W-1:0]   evt;

   assign wr_ctrl = wr_en && (addr == ssa_pkg::ADDR_CTRL);
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   // next enable and master values, software write then hardware clears
   always_comb begin
      next_en  = wr_ctrl ? wdata[ssa_pkg::BIT_EN] : controller_enable;
      next_mst = wr_ctrl ? wdata[ssa_pkg::BIT_MST] : master_select;
      if (addr_match_evt || arb_lost_evt || gc_evt || !next_en) begin
         next_mst = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         controller_enable <= 1'b0;
         master_select     <= 1'b0;
      end else begin
         controller_enable <= next_en;
         master_select     <= next_mst;
      end
   end

   // configuration bits, transfer mode stored only while master select is set; reserved positions are never stored
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         transfer_mode        <= 1'b0;
         stretch_point_select <= 1'b0;
         general_call_accept  <= 1'b0;
         stretch_enable       <= 1'b0;
      end else if (wr_ctrl) begin
         if (master_select) begin
            transfer_mode <= wdata[ssa_pkg::BIT_MODE];
         end
         stretch_point_select <= wdata[ssa_pkg::BIT_STRS];
         general_call_accept  <= wdata[ssa_pkg::BIT_GCEN];
         stretch_enable       <= wdata[ssa_pkg::BIT_STREN];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ack_select <= 1'b0;
      end else if (controller_abort) begin
         ack_select <= 1'b1;
      end else if (wr_ctrl) begin
         ack_select <= wdata[ssa_pkg::BIT_ACK];
      end
   end

   // abort: set by software only, cleared after the internal reset or on disable
   assign abort_done = controller_abort && (abort_cnt == 4'(ABORT_LEN - 1));
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         controller_abort <= 1'b0;
         abort_cnt        <= 4'h0;
      end else if (!next_en) begin
         controller_abort <= 1'b0;
         abort_cnt        <= 4'h0;
      end else if (controller_abort) begin
         abort_cnt <= abort_cnt + 4'h1;
         if (abort_done) begin
            controller_abort <= 1'b0;
            abort_cnt        <= 4'h0;
         end
      end else if (wr_ctrl && wdata[ssa_pkg::BIT_ABORT]) begin
         controller_abort <= 1'b1;
      end
   end

   // start and stop requests are mutually exclusive
   assign set_stop  = wr_ctrl && wdata[ssa_pkg::BIT_STOP] && !wdata[ssa_pkg::BIT_START]
                      && !start_request && next_en && next_mst && !controller_abort;
   assign set_start = wr_ctrl && wdata[ssa_pkg::BIT_START] && !wdata[ssa_pkg::BIT_STOP]
                      && !stop_request && next_en && next_mst && !controller_abort;
   assign timeout_hit = timeout_expired && stop_request;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stop_request <= 1'b0;
      end else if (!next_en || !next_mst || controller_abort) begin
         stop_request <= 1'b0;
      end else if (set_stop) begin
         stop_request <= 1'b1;
      end else if (stop_done || timeout_hit) begin
         stop_request <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         start_request <= 1'b0;
      end else if (!next_en || !next_mst || controller_abort) begin
         start_request <= 1'b0;
      end else if (set_start) begin
         start_request <= 1'b1;
      end else if (start_done || (timeout_expired && start_request)) begin
         start_request <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         timeout_start <= 1'b0;
      end else begin
         timeout_start <= (set_stop || set_start) && timeout_en;
      end
   end

   // stop sequence: SCL low, SDA low, release SCL, release SDA
   assign stop_done = (stop_state == ssa_pkg::SSA_STOP_SDAHI)
                      && (phase_cnt == 8'(STOP_PHASE - 1));
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stop_state <= ssa_pkg::SSA_STOP_IDLE;
         phase_cnt  <= 8'h00;
      end else if (controller_abort || timeout_hit || !stop_request) begin
         stop_state <= ssa_pkg::SSA_STOP_IDLE;
         phase_cnt  <= 8'h00;
      end else begin
         case (stop_state)
            ssa_pkg::SSA_STOP_IDLE: begin
               stop_state <= ssa_pkg::SSA_STOP_LOW;
               phase_cnt  <= 8'h00;
            end
            ssa_pkg::SSA_STOP_LOW: begin
               phase_cnt <= phase_cnt + 8'h01;
               if (phase_cnt == 8'(2 * STOP_PHASE - 1)) begin
                  stop_state <= ssa_pkg::SSA_STOP_SCLHI;
                  phase_cnt  <= 8'h00;
               end
            end
            ssa_pkg::SSA_STOP_SCLHI: begin
               // another device may stretch; wait for SCL high before timing
               if (scl_s) begin
                  phase_cnt <= phase_cnt + 8'h01;
               end
               if (scl_s && phase_cnt == 8'(STOP_PHASE - 1)) begin
                  stop_state <= ssa_pkg::SSA_STOP_SDAHI;
                  phase_cnt  <= 8'h00;
               end
            end
            ssa_pkg::SSA_STOP_SDAHI: begin
               phase_cnt <= phase_cnt + 8'h01;
            end
            default: begin
               stop_state <= ssa_pkg::SSA_STOP_IDLE;
               phase_cnt  <= 8'h00;
            end
         endcase
      end
   end

   // pin synchronisers and bus edge detection
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_q <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_q <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_q <= sda_s;
      end
   end

   assign scl_rise  = scl_s && !scl_q;
   assign scl_fall  = !scl_s && scl_q;
   assign bus_start = scl_s && scl_q && sda_q && !sda_s;
   assign next_bit  = (bit_cnt == ssa_pkg::BITS_PER_ACK) ? 4'h1 : bit_cnt + 4'h1;

   // bit counter and address shifter
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bit_cnt    <= 4'h0;
         first_byte <= 1'b0;
         shreg      <= 8'h00;
      end else if (!controller_enable || controller_abort) begin
         bit_cnt    <= 4'h0;
         first_byte <= 1'b0;
      end else if (bus_start) begin
         // the fall right after START ends no clock: all ones wraps to 0 on it
         bit_cnt    <= '1;
         first_byte <= 1'b1;
      end else begin
         if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
         end
         if (scl_fall) begin
            bit_cnt <= next_bit;
            if (next_bit == ssa_pkg::BITS_PER_ACK) begin
               first_byte <= 1'b0;
            end
         end
      end
   end

   // general call: answer the all-zero address during the ack clock
   assign gc_evt = scl_fall && first_byte && (next_bit == ssa_pkg::STRETCH_AT_8)
                   && (shreg == ssa_pkg::GC_ADDR) && general_call_accept
                   && controller_enable && !controller_abort;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gc_drive <= 1'b0;
      end else if (!controller_enable || controller_abort || bus_start) begin
         gc_drive <= 1'b0;
      end else if (gc_evt) begin
         gc_drive <= !ack_select;
      end else if (scl_fall) begin
         gc_drive <= 1'b0;
      end
   end

   // clock stretch hold, released by any control word write
   assign hold_set = scl_fall && stretch_enable && controller_enable && !controller_abort
                     && (next_bit == (stretch_point_select ? ssa_pkg::STRETCH_AT_8
                                                            : ssa_pkg::STRETCH_AT_9));
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hold <= 1'b0;
      end else if (!stretch_enable || !controller_enable || controller_abort) begin
         hold <= 1'b0;
      end else if (hold_set) begin
         hold <= 1'b1;
      end else if (wr_ctrl) begin
         hold <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else begin
         scl_oe_n <= !(hold || stop_state == ssa_pkg::SSA_STOP_LOW);
         sda_oe_n <= !(gc_drive || stop_state == ssa_pkg::SSA_STOP_SCLHI
                       || (stop_state == ssa_pkg::SSA_STOP_LOW
                           && phase_cnt >= 8'(STOP_PHASE)));
      end
   end

   // event status, write one to clear, a new event wins over the clear
   always_comb begin
      evt = '0;
      evt[ssa_pkg::EVT_STOP]    = stop_done;
      evt[ssa_pkg::EVT_TIMEOUT] = timeout_hit;
      evt[ssa_pkg::EVT_GCALL]   = gc_evt;
      evt[ssa_pkg::EVT_ABORT]   = abort_done;
      evt[ssa_pkg::EVT_STRETCH] = hold_set;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status <= ssa_pkg::STAT_RESET;
         mask   <= ssa_pkg::MASK_RESET;
      end else begin
         if (wr_en && addr == ssa_pkg::ADDR_STAT) begin
            status <= (status & ~wdata[ssa_pkg::EVT_W-1:0]) | evt;
         end else begin
            status <= status | evt;
         end
         if (wr_en && addr == ssa_pkg::ADDR_MASK) begin
            mask <= wdata[ssa_pkg::EVT_W-1:0];
         end
      end
   end

   assign irq = |(status & mask);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd_en) begin
         rdata <= '0;
         case (addr)
            ssa_pkg::ADDR_CTRL: begin
               rdata[ssa_pkg::BIT_EN]    <= controller_enable;
               rdata[ssa_pkg::BIT_MST]   <= master_select;
               rdata[ssa_pkg::BIT_MODE]  <= transfer_mode;
               rdata[ssa_pkg::BIT_STRS]  <= stretch_point_select;
               rdata[ssa_pkg::BIT_ACK]   <= ack_select;
               rdata[ssa_pkg::BIT_START] <= start_request;
               rdata[ssa_pkg::BIT_STOP]  <= stop_request;
               rdata[ssa_pkg::BIT_GCEN]  <= general_call_accept;
               rdata[ssa_pkg::BIT_STREN] <= stretch_enable;
               rdata[ssa_pkg::BIT_ABORT] <= controller_abort;
            end
            ssa_pkg::ADDR_STAT: rdata[ssa_pkg::EVT_W-1:0] <= status;
            ssa_pkg::ADDR_MASK: rdata[ssa_pkg::EVT_W-1:0] <= mask;
            default: rdata <= '0;
         endcase
      end
   end

   stop_gated_a: assert property (@(posedge sys_clk) disable iff (rst)
      stop_request |-> controller_enable && master_select)
      else $error("stop request set while disabled or slave");
   stop_exclusive_a: assert property (@(posedge sys_clk) disable iff (rst)
      wr_ctrl && wdata[ssa_pkg::BIT_STOP] && start_request |=> !stop_request)
      else $error("stop request accepted while start pending");
   stop_selfclr_a: assert property (@(posedge sys_clk) disable iff (rst)
      stop_done |=> !stop_request && status[ssa_pkg::EVT_STOP])
      else $error("stop request not cleared after stop");
   timeout_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
      timeout_expired && stop_request |=> !stop_request && status[ssa_pkg::EVT_TIMEOUT])
      else $error("timeout did not clear stop request");
   timer_kick_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(stop_request) |-> timeout_start == $past(timeout_en))
      else $error("timeout timer start mismatch");
   abort_ack_a: assert property (@(posedge sys_clk) disable iff (rst)
      controller_abort |=> ack_select)
      else $error("ack select not forced during abort");
   abort_finish_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(controller_abort) |-> ##[1:ABORT_BOUND] !controller_abort)
      else $error("abort bit not cleared by hardware");
   abort_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
      controller_abort |=> stop_state == ssa_pkg::SSA_STOP_IDLE && !hold && !stop_request)
      else $error("abort left internal state active");
   stretch_off_a: assert property (@(posedge sys_clk) disable iff (rst)
      !stretch_enable ##1 !stretch_enable |-> !hold)
      else $error("clock stretched while disabled");
   gcall_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
      gc_evt |-> general_call_accept ##1 !master_select)
      else $error("general call answered while not accepted");
   master_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
      addr_match_evt || arb_lost_evt |=> !master_select)
      else $error("master select not cleared by hardware event");
   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      rd_en && addr == ssa_pkg::ADDR_CTRL |=> rdata[14:10] == 5'h00)
      else $error("reserved control bits read nonzero");
endmodule

// ### sim/ssa_bus_dev.sv
`timescale 1ns/1ps
module ssa_bus_dev (
   // device side of the wires
   input  wire logic scl_oe_n,
   input  wire logic sda_oe_n,
   // resolved wires, both pulled up
   output logic      scl,
   output logic      sda,
   // what was seen on the wires
   output int        hold_at,
   output int        stops
);
   logic m_scl = 1'b1;
   logic m_sda = 1'b1;
   int   falls = 0;
   assign scl = m_scl & scl_oe_n;
   assign sda = m_sda & sda_oe_n;
   initial stops = 0;
   initial hold_at = 0;
   always @(negedge scl) falls++;
   always @(negedge scl_oe_n) hold_at = falls;
   always @(posedge sda) if (scl === 1'b1) stops++;
   // 800 ns link clock, only inside a frame; a stretched scl is waited out
   task automatic frame(input logic [7:0] b, input int n);
      // keep the wires off the system clock edges
      #10 m_sda = 1'b0;
      falls = 0;
      hold_at = 0;
      for (int i = 0; i <= n; i++) begin
         #400 m_scl = 1'b0;
         #200 m_sda = (i < 8) ? b[7-i] : (i != n);
         #200 m_scl = 1'b1;
         wait (scl === 1'b1);
      end
      #400 m_sda = 1'b1;
   endtask
endmodule

// ### sim/ssa_ctrl_tb.sv
`timescale 1ns/1ps
module ssa_ctrl_tb;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic        wr_en = 1'b0, rd_en = 1'b0, start_done = 1'b0, addr_match_evt = 1'b0;
   logic        arb_lost_evt = 1'b0, timeout_en = 1'b0, timeout_expired = 1'b0;
   logic [15:0] rdata, w;
   logic        irq, timeout_start, controller_enable, master_select, transfer_mode;
   logic        start_request, stretch_point_select, ack_select, scl_oe_n, sda_oe_n, scl, sda;
   int          fails = 0, checks_done = 0, hold_at, stops, n0;
   ssa_ctrl #(.STOP_PHASE(4), .ABORT_LEN(4)) dut (.sys_clk, .rst, .addr, .wdata, .wr_en,
      .rd_en, .rdata, .irq, .start_done, .addr_match_evt, .arb_lost_evt, .timeout_en,
      .timeout_expired, .timeout_start, .controller_enable, .master_select, .transfer_mode,
      .start_request, .stretch_point_select, .ack_select, .scl_in(scl), .scl_out(),
      .scl_oe_n, .sda_in(sda), .sda_out(), .sda_oe_n);
   ssa_bus_dev dev (.scl_oe_n, .sda_oe_n, .scl, .sda, .hold_at, .stops);
   always #50 sys_clk = ~sys_clk;
   function automatic int exp_hold(input int sp);
      // falls are counted from START, the one right after it included
      return sp ? 9 : 10;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input int a, input logic [15:0] d);
      @(posedge sys_clk) begin addr <= 4'(a); wdata <= d; wr_en <= 1'b1; end
      @(posedge sys_clk) wr_en <= 1'b0;
   endtask
   task automatic rd(input int a);
      @(posedge sys_clk) begin addr <= 4'(a); rd_en <= 1'b1; end
      @(posedge sys_clk) rd_en <= 1'b0;
      #1;
   endtask
   task automatic rc(input int a, input logic [15:0] exp, input logic [15:0] m);
      rd(a);
      chk(rdata & m, exp);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #3_000_000 fails++;
      tally_and_finish();
   end
   initial begin
      w = 16'($urandom(14417));
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      rc(0, 16'h0000, 16'hffff);
      chk(16'(irq), 16'h0000);
      n0 = stops;
      wr(0, 16'h0082);
      rc(0, 16'h0000, 16'h0080);
      wr(0, 16'h0081);
      rc(0, 16'h0000, 16'h0080);
      chk(16'(stops - n0), 16'h0000);
      $display("slave stop done");
      timeout_en <= 1'b1;
      wr(0, 16'h0003);
      wr(0, 16'h0083);
      #1 chk(16'(timeout_start), 16'h0001);
      rc(0, 16'h0080, 16'h0080);
      for (int i = 0; i < 80 && rdata[7] !== 1'b0; i++) rd(0);
      rc(0, 16'h0003, 16'hffff);
      chk(16'(stops - n0), 16'h0001);
      rc(4, 16'h0001, 16'h001f);
      chk(16'(irq), 16'h0000);
      wr(8, 16'h0001);
      #1 chk(16'(irq), 16'h0001);
      wr(4, 16'h001f);
      #1 chk(16'(irq), 16'h0000);
      $display("stop done");
      wr(0, 16'h0043);
      #1 chk(16'(start_request), 16'h0001);
      wr(0, 16'h0083);
      rc(0, 16'h0000, 16'h0080);
      @(posedge sys_clk) start_done <= 1'b1;
      @(posedge sys_clk) start_done <= 1'b0;
      wr(0, 16'h00c3);
      rc(0, 16'h0000, 16'h00c0);
      timeout_en <= 1'b0;
      wr(0, 16'h0083);
      #1 chk(16'(timeout_start), 16'h0000);
      @(posedge sys_clk) timeout_expired <= 1'b1;
      @(posedge sys_clk) timeout_expired <= 1'b0;
      rc(0, 16'h0000, 16'h0080);
      rc(4, 16'h0002, 16'h0003);
      wr(8, 16'h0002);
      #1 chk(16'(irq), 16'h0001);
      wr(4, 16'h001f);
      $display("start and timeout done");
      wr(0, 16'h0083);
      wr(0, 16'h8003);
      wr(0, 16'h0003);
      #1 chk(16'(ack_select), 16'h0001);
      rc(0, 16'h8000, 16'h8000);
      for (int i = 0; i < 20 && rdata[15] !== 1'b0; i++) rd(0);
      rc(0, 16'h0000, 16'h8080);
      rc(4, 16'h0008, 16'h0009);
      wr(0, 16'h8001);
      wr(0, 16'h0000);
      rc(0, 16'h0000, 16'h8000);
      $display("abort done");
      for (int k = 0; k < 2; k++) begin
         wr(0, 16'h0003);
         @(posedge sys_clk) if (k) arb_lost_evt <= 1'b1; else addr_match_evt <= 1'b1;
         @(posedge sys_clk) begin arb_lost_evt <= 1'b0; addr_match_evt <= 1'b0; end
         #1 chk(16'(master_select), 16'h0000);
      end
      w = 16'($urandom) & 16'h7c00 | 16'h0001;
      wr(0, w);
      rc(0, 16'h0001, 16'hffff);
      for (int k = 0; k < 3; k++) begin
         wr(0, (k == 1) ? 16'h0013 : 16'h0103);
         wr(4, 16'h001f);
         dev.frame((k == 2) ? 8'($urandom_range(1, 255)) : 8'h00, 9);
         rc(4, (k == 0) ? 16'h0004 : 16'h0000, 16'h0004);
         chk(16'(master_select), (k == 0) ? 16'h0000 : 16'h0001);
         chk(16'(hold_at), 16'h0000);
      end
      $display("general call done");
      for (int sp = 0; sp < 2; sp++) begin
         w = 16'h0201 | 16'(sp << 4);
         wr(0, w);
         #1 chk(16'(stretch_point_select), 16'(sp));
         fork
            dev.frame(8'($urandom), 9);
            begin
               for (int i = 0; i < 300 && scl_oe_n !== 1'b0; i++) @(posedge sys_clk);
               wr(0, w);
            end
         join
         chk(16'(hold_at), 16'(exp_hold(sp)));
      end
      $display("stretch done");
      tally_and_finish();
   end
endmodule
